// *** mtp_pkg.sv ***
// constants for the transceiver pin interface block
// assumes one core clock of 10 MHz shared with the protocol engine
package mtp_pkg;

  // -------------------------------------------------------------------
  // clock and timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TT_RES_NS = 64000;
  localparam int TT_TICK_CYCLES = TT_RES_NS / CLK_PERIOD_NS;
  localparam int TT_PRESCALE_W = 10;
  localparam logic [TT_PRESCALE_W-1:0] TT_TICK_LAST =
    TT_PRESCALE_W'(TT_TICK_CYCLES - 1);
  localparam int PROBE_FREQ_KHZ = 500;
  localparam int PROBE_HALF_NS = 1000000 / (2 * PROBE_FREQ_KHZ);
  localparam int PROBE_HALF_CYCLES = PROBE_HALF_NS / CLK_PERIOD_NS;
  localparam int PROBE_CNT_W = 4;
  localparam logic [PROBE_CNT_W-1:0] PROBE_HALF_LAST =
    PROBE_CNT_W'(PROBE_HALF_CYCLES - 1);

  // -------------------------------------------------------------------
  // widths and field positions
  // -------------------------------------------------------------------
  localparam int TT_W = 16;
  localparam int TT_MSB = TT_W - 1;
  localparam int WORD_W = 16;
  localparam int CMD_LSB_W = 11;
  localparam int LINK_COUNT = 31;
  localparam int LINK_IDX_W = 5;
  localparam logic [LINK_IDX_W-1:0] BROADCAST_ADDR = 5'h1f;

  // -------------------------------------------------------------------
  // hub topology codes and reset values
  // -------------------------------------------------------------------
  localparam int TOPO_SPEC_BIT = 1;
  localparam logic [1:0] TOPO_SWITCH = 2'h2;
  localparam logic [1:0] TOPO_LINK = 2'h3;
  localparam logic GATE_RESET = 1'h1;
  localparam logic DECODE_GOOD_RESET = 1'h1;
  localparam logic RX_IDLE = 1'h1;

endpackage : mtp_pkg

// *** mtp_tx_gate.sv ***
// one bus's transmit gate and drive outputs
// assumes transmit data and activity are synchronous to the core clock
`timescale 1ns/1ps
module mtp_tx_gate (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic standard_transceiver_select_i,
  input wire logic transmitting_i,
  input wire logic tx_pos_i,
  input wire logic tx_neg_i,
  output logic tx_gate_o,
  output logic std_pos_o,
  output logic std_neg_o,
  output logic disc_pos_o,
  output logic disc_neg_o
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic gate;
    logic std_pos;
    logic std_neg;
    logic disc_pos;
    logic disc_neg;
  } mtp_gate_state_t;

  mtp_gate_state_t state;
  mtp_gate_state_t next_state;

  always_comb begin
    next_state = state;
    if (standard_transceiver_select_i) begin
      next_state.gate = ~transmitting_i;
      next_state.std_pos = tx_pos_i & transmitting_i;
      next_state.std_neg = tx_neg_i & transmitting_i;
      next_state.disc_pos = 1'b0;
      next_state.disc_neg = 1'b0;
    end else begin
      next_state.gate = transmitting_i;
      next_state.std_pos = 1'b0;
      next_state.std_neg = 1'b0;
      next_state.disc_pos = tx_pos_i & transmitting_i;
      next_state.disc_neg = tx_neg_i & transmitting_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '{gate: mtp_pkg::GATE_RESET, default: 1'b0};
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  assign tx_gate_o = state.gate;
  assign std_pos_o = state.std_pos;
  assign std_neg_o = state.std_neg;
  assign disc_pos_o = state.disc_pos;
  assign disc_neg_o = state.disc_neg;

endmodule : mtp_tx_gate

// *** mtp_pin_if.sv ***
// pin-level glue between the protocol engine and the line transceivers
// assumes all inputs are synchronous to ref_clk_i at 10 MHz
//
// Overview of operation
// - controller strip high forces controller mode off; low lets software decide.
// - monitor strip high forces monitor mode off; low lets software decide.
// - terminal strip high forces terminal mode off; low lets software decide.
// - select high means standard transceiver, low means discrete drive outputs.
// - standard transceiver: per-bus gate low while sending, high otherwise.
// - discrete transceiver: per-bus gate acts as enable, high while sending; reset loads it high.
// - hub topology 0x all links, 10 link equals terminal, 11 single link.
// - link topology takes the common terminal address from address pins.
// - hub has 31 transmit, receive and active-high enable lines; low undriven.
// - time tag top bit is a probe; cleared to zero while reset is held.
// - a 500 kHz probe clock derived from the core clock.
// - receive strobe probe pulses at parity end of every word, either bus.
// - decode-good probe high for valid words, low on decode errors.
// - bus A sync-type probe high for command sync, low for data sync.
// - bus A activity probe high while the two receive lines differ.
// - one core-clock strobe pulse per attack cycle qualifies descriptors; bus A wins a tie.
// - attack bus flag is one for bus A, zero for bus B.
// - attack time stamp is 16 time tag bits at detection.
`timescale 1ns/1ps
module mtp_pin_if (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic controller_mode_strip_i,
  input wire logic monitor_mode_strip_i,
  input wire logic terminal_mode_strip_i,
  input wire logic sw_controller_enable_i,
  input wire logic sw_monitor_enable_i,
  input wire logic sw_terminal_enable_i,
  input wire logic standard_transceiver_select_i,
  input wire logic bus_a_transmitting_i,
  input wire logic bus_b_transmitting_i,
  input wire logic bus_a_tx_pos_i,
  input wire logic bus_a_tx_neg_i,
  input wire logic bus_b_tx_pos_i,
  input wire logic bus_b_tx_neg_i,
  input wire logic bus_a_receive_pos_i,
  input wire logic bus_a_receive_neg_i,
  input wire logic bus_a_word_done_i,
  input wire logic bus_b_word_done_i,
  input wire logic bus_a_word_error_i,
  input wire logic bus_b_word_error_i,
  input wire logic bus_a_mid_sync_i,
  input wire logic bus_a_command_sync_i,
  input wire logic bus_b_command_sync_i,
  input wire logic [15:0] bus_a_word_i,
  input wire logic [15:0] bus_b_word_i,
  input wire logic [1:0] hub_topology_select_i,
  input wire logic hub_transmitting_i,
  input wire logic hub_tx_data_i,
  input wire logic [4:0] hub_target_terminal_i,
  input wire logic [4:0] hub_link_select_i,
  input wire logic [4:0] hub_reply_link_i,
  input wire logic [30:0] hub_link_rx_i,
  input wire logic [4:0] terminal_address_pins_i,
  input wire logic terminal_address_parity_pin_i,
  output logic controller_mode_en_o,
  output logic monitor_mode_en_o,
  output logic terminal_mode_en_o,
  output logic bus_a_tx_gate_o,
  output logic bus_b_tx_gate_o,
  output logic bus_a_std_pos_o,
  output logic bus_a_std_neg_o,
  output logic bus_b_std_pos_o,
  output logic bus_b_std_neg_o,
  output logic bus_a_disc_pos_o,
  output logic bus_a_disc_neg_o,
  output logic bus_b_disc_pos_o,
  output logic bus_b_disc_neg_o,
  output logic [30:0] hub_link_tx_o,
  output logic [30:0] line_driver_enables_o,
  output logic hub_rx_o,
  output logic [4:0] hub_common_address_o,
  output logic hub_common_address_ok_o,
  output logic time_tag_top_bit_probe_o,
  output logic half_megahertz_probe_o,
  output logic rx_strobe_probe_o,
  output logic decode_good_probe_o,
  output logic bus_a_sync_type_probe_o,
  output logic bus_a_activity_probe_o,
  output logic attack_report_strobe_o,
  output logic [15:0] attack_command_o,
  output logic attack_bus_a_o,
  output logic [15:0] attack_time_stamp_o
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [mtp_pkg::TT_PRESCALE_W-1:0] tick_cnt;
    logic [mtp_pkg::TT_W-1:0] time_tag;
    logic [mtp_pkg::PROBE_CNT_W-1:0] half_cnt;
    logic half_clk;
    logic ctl_en;
    logic mon_en;
    logic term_en;
    logic rx_strobe;
    logic decode_good;
    logic sync_type;
    logic activity;
    logic atk_strobe;
    logic [mtp_pkg::WORD_W-1:0] atk_cmd;
    logic atk_bus_a;
    logic [mtp_pkg::TT_W-1:0] atk_stamp;
    logic [mtp_pkg::LINK_COUNT-1:0] hub_tx;
    logic [mtp_pkg::LINK_COUNT-1:0] hub_de;
    logic hub_rx;
    logic [mtp_pkg::LINK_IDX_W-1:0] hub_addr;
    logic hub_addr_ok;
  } mtp_state_t;

  mtp_state_t state;
  mtp_state_t next_state;

  logic atk_a;
  logic atk_b;
  logic [mtp_pkg::LINK_IDX_W-1:0] hub_sel;
  logic [mtp_pkg::LINK_IDX_W-1:0] rx_sel;

  // -------------------------------------------------------------------
  // per-bus transmit gates
  // -------------------------------------------------------------------
  mtp_tx_gate u_gate_a (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .standard_transceiver_select_i(standard_transceiver_select_i),
    .transmitting_i(bus_a_transmitting_i),
    .tx_pos_i(bus_a_tx_pos_i),
    .tx_neg_i(bus_a_tx_neg_i),
    .tx_gate_o(bus_a_tx_gate_o),
    .std_pos_o(bus_a_std_pos_o),
    .std_neg_o(bus_a_std_neg_o),
    .disc_pos_o(bus_a_disc_pos_o),
    .disc_neg_o(bus_a_disc_neg_o)
  );

  mtp_tx_gate u_gate_b (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .standard_transceiver_select_i(standard_transceiver_select_i),
    .transmitting_i(bus_b_transmitting_i),
    .tx_pos_i(bus_b_tx_pos_i),
    .tx_neg_i(bus_b_tx_neg_i),
    .tx_gate_o(bus_b_tx_gate_o),
    .std_pos_o(bus_b_std_pos_o),
    .std_neg_o(bus_b_std_neg_o),
    .disc_pos_o(bus_b_disc_pos_o),
    .disc_neg_o(bus_b_disc_neg_o)
  );

  // -------------------------------------------------------------------
  // attack detection
  // -------------------------------------------------------------------
  // command-sync words with any of the low bits set
  assign atk_a = bus_a_word_done_i & bus_a_command_sync_i &
    (|bus_a_word_i[mtp_pkg::CMD_LSB_W-1:0]);
  assign atk_b = bus_b_word_done_i & bus_b_command_sync_i &
    (|bus_b_word_i[mtp_pkg::CMD_LSB_W-1:0]);

  // -------------------------------------------------------------------
  // hub link selection
  // -------------------------------------------------------------------
  // switch topology follows the terminal, link topology the link select
  assign hub_sel = (hub_topology_select_i == mtp_pkg::TOPO_SWITCH) ?
    hub_target_terminal_i : hub_link_select_i;
  assign rx_sel = hub_topology_select_i[mtp_pkg::TOPO_SPEC_BIT] ?
    hub_sel : hub_reply_link_i;

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    next_state = state;

    // mode straps override software
    next_state.ctl_en = sw_controller_enable_i &
      ~controller_mode_strip_i;
    next_state.mon_en = sw_monitor_enable_i &
      ~monitor_mode_strip_i;
    next_state.term_en = sw_terminal_enable_i &
      ~terminal_mode_strip_i;

    // time tag at 64 us per tick
    if (state.tick_cnt == mtp_pkg::TT_TICK_LAST) begin
      next_state.tick_cnt = '0;
      next_state.time_tag = state.time_tag + 16'h0001;
    end else begin
      next_state.tick_cnt = state.tick_cnt + 10'h001;
    end

    // probe clock toggles every half period
    if (state.half_cnt == mtp_pkg::PROBE_HALF_LAST) begin
      next_state.half_cnt = '0;
      next_state.half_clk = ~state.half_clk;
    end else begin
      next_state.half_cnt = state.half_cnt + 4'h1;
    end

    // decoder probes
    next_state.rx_strobe = bus_a_word_done_i | bus_b_word_done_i;
    if ((bus_a_word_done_i & bus_a_word_error_i) |
        (bus_b_word_done_i & bus_b_word_error_i)) begin
      next_state.decode_good = 1'b0;
    end else if (bus_a_word_done_i | bus_b_word_done_i) begin
      next_state.decode_good = 1'b1;
    end
    if (bus_a_mid_sync_i) begin
      next_state.sync_type = bus_a_command_sync_i;
    end
    next_state.activity = bus_a_receive_pos_i ^
      bus_a_receive_neg_i;

    // attack report, bus A wins a tie
    next_state.atk_strobe = atk_a | atk_b;
    if (atk_a) begin
      next_state.atk_cmd = bus_a_word_i;
      next_state.atk_bus_a = 1'b1;
      next_state.atk_stamp = state.time_tag;
    end else if (atk_b) begin
      next_state.atk_cmd = bus_b_word_i;
      next_state.atk_bus_a = 1'b0;
      next_state.atk_stamp = state.time_tag;
    end

    // hub driver enables and transmit lines
    next_state.hub_de = '0;
    for (int i = 0; i < mtp_pkg::LINK_COUNT; i++) begin
      if (hub_transmitting_i) begin
        if (!hub_topology_select_i[mtp_pkg::TOPO_SPEC_BIT]) begin
          next_state.hub_de[i] = 1'b1;
        end else if (hub_sel == mtp_pkg::BROADCAST_ADDR) begin
          next_state.hub_de[i] = 1'b1;
        end else if (hub_sel == mtp_pkg::LINK_IDX_W'(i)) begin
          next_state.hub_de[i] = 1'b1;
        end
      end
    end
    next_state.hub_tx = {mtp_pkg::LINK_COUNT{hub_tx_data_i}} &
      next_state.hub_de;

    // hub receive from the replying link
    if (rx_sel == mtp_pkg::BROADCAST_ADDR) begin
      next_state.hub_rx = mtp_pkg::RX_IDLE;
    end else begin
      next_state.hub_rx = hub_link_rx_i[rx_sel];
    end

    // common terminal address in link topology, odd parity
    next_state.hub_addr = terminal_address_pins_i;
    next_state.hub_addr_ok = (hub_topology_select_i == mtp_pkg::TOPO_LINK) &
      (^{terminal_address_pins_i, terminal_address_parity_pin_i});
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= '{decode_good: mtp_pkg::DECODE_GOOD_RESET,
                 hub_rx: mtp_pkg::RX_IDLE,
                 default: '0};
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign controller_mode_en_o = state.ctl_en;
  assign monitor_mode_en_o = state.mon_en;
  assign terminal_mode_en_o = state.term_en;
  assign hub_link_tx_o = state.hub_tx;
  assign line_driver_enables_o = state.hub_de;
  assign hub_rx_o = state.hub_rx;
  assign hub_common_address_o = state.hub_addr;
  assign hub_common_address_ok_o = state.hub_addr_ok;
  assign time_tag_top_bit_probe_o = state.time_tag[mtp_pkg::TT_MSB];
  assign half_megahertz_probe_o = state.half_clk;
  assign rx_strobe_probe_o = state.rx_strobe;
  assign decode_good_probe_o = state.decode_good;
  assign bus_a_sync_type_probe_o = state.sync_type;
  assign bus_a_activity_probe_o = state.activity;
  assign attack_report_strobe_o = state.atk_strobe;
  assign attack_command_o = state.atk_cmd;
  assign attack_bus_a_o = state.atk_bus_a;
  assign attack_time_stamp_o = state.atk_stamp;

endmodule : mtp_pin_if

// *** mtp_xcvr_model.sv ***
// behavioural line transceiver for one bus and hub line drivers
// assumes drive levels come straight from the pin interface outputs
`timescale 1ns/1ps
module mtp_xcvr_model (
  input wire logic select_i,
  input wire logic tx_gate_i,
  input wire logic std_pos_i,
  input wire logic std_neg_i,
  input wire logic disc_pos_i,
  input wire logic disc_neg_i,
  input wire logic [30:0] hub_tx_i,
  input wire logic [30:0] hub_en_i,
  output logic rx_pos_o,
  output logic rx_neg_o,
  output logic [30:0] hub_rx_o
);
  // ---------------------------------------------------------------
  // loopback of own transmission, quiet bus reads low
  // ---------------------------------------------------------------
  logic driving;
  assign driving = select_i ? ~tx_gate_i : tx_gate_i;
  assign rx_pos_o = driving & (select_i ? std_pos_i : disc_pos_i);
  assign rx_neg_o = driving & (select_i ? std_neg_i : disc_neg_i);
  // undriven lines sit at the fail-safe bias level
  assign hub_rx_o = (hub_tx_i & hub_en_i) | ~hub_en_i;
endmodule : mtp_xcvr_model

// *** mtp_pin_if_assertions.sv ***
// port-level checks for the transceiver pin interface
// assumes one core clock and active-high asynchronous reset
`timescale 1ns/1ps
module mtp_pin_if_checker (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic controller_mode_strip_i,
  input wire logic sw_controller_enable_i,
  input wire logic controller_mode_en_o,
  input wire logic monitor_mode_strip_i,
  input wire logic sw_monitor_enable_i,
  input wire logic monitor_mode_en_o,
  input wire logic standard_transceiver_select_i,
  input wire logic bus_a_transmitting_i,
  input wire logic bus_a_tx_gate_o,
  input wire logic bus_a_receive_pos_i,
  input wire logic bus_a_receive_neg_i,
  input wire logic bus_a_activity_probe_o,
  input wire logic bus_a_word_done_i,
  input wire logic bus_b_word_done_i,
  input wire logic bus_a_word_error_i,
  input wire logic bus_b_word_error_i,
  input wire logic rx_strobe_probe_o,
  input wire logic decode_good_probe_o,
  input wire logic bus_a_command_sync_i,
  input wire logic [15:0] bus_a_word_i,
  input wire logic attack_report_strobe_o,
  input wire logic [15:0] attack_command_o,
  input wire logic attack_bus_a_o,
  input wire logic [15:0] attack_time_stamp_o,
  input wire logic half_megahertz_probe_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_ctl_mode;
    ce_i |=> controller_mode_en_o ==
      $past(sw_controller_enable_i & ~controller_mode_strip_i);
  endproperty
  a_ctl_mode: assert property (p_ctl_mode)
    else $error("controller mode enable wrong");
  property p_mon_mode;
    ce_i |=> monitor_mode_en_o ==
      $past(sw_monitor_enable_i & ~monitor_mode_strip_i);
  endproperty
  a_mon_mode: assert property (p_mon_mode)
    else $error("monitor mode enable wrong");
  property p_gate;
    ce_i |=> bus_a_tx_gate_o ==
      $past(standard_transceiver_select_i ^ bus_a_transmitting_i);
  endproperty
  a_gate: assert property (p_gate)
    else $error("transmit gate polarity wrong");
  property p_activity;
    ce_i |=> bus_a_activity_probe_o ==
      $past(bus_a_receive_pos_i ^ bus_a_receive_neg_i);
  endproperty
  a_activity: assert property (p_activity)
    else $error("activity probe wrong");
  property p_strobe;
    ce_i |=> rx_strobe_probe_o == $past(bus_a_word_done_i | bus_b_word_done_i);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("receive strobe wrong");
  property p_bad_word;
    ce_i && ((bus_a_word_done_i && bus_a_word_error_i) ||
      (bus_b_word_done_i && bus_b_word_error_i)) |=> !decode_good_probe_o;
  endproperty
  a_bad_word: assert property (p_bad_word)
    else $error("decode good stayed high on error");
  property p_attack_a;
    ce_i && bus_a_word_done_i && bus_a_command_sync_i &&
      (|bus_a_word_i[10:0]) |=> attack_report_strobe_o && attack_bus_a_o &&
      attack_command_o == $past(bus_a_word_i);
  endproperty
  a_attack_a: assert property (p_attack_a)
    else $error("bus a attack not reported");
  property p_hold;
    !attack_report_strobe_o |-> $stable(attack_command_o) &&
      $stable(attack_bus_a_o) && $stable(attack_time_stamp_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("attack descriptors moved without strobe");
  property p_half;
    $changed(half_megahertz_probe_o) |=> $stable(half_megahertz_probe_o)[*8];
  endproperty
  a_half: assert property (p_half)
    else $error("half megahertz probe toggles too fast");
endmodule : mtp_pin_if_checker

bind mtp_pin_if mtp_pin_if_checker chk (.*);

// *** test_mtp_pin_if.sv ***
// self-checking bench for the transceiver pin interface
// assumes a 10 MHz core clock and the transceiver model on the far side
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  fails++; $display("wrong value %s expected %h seen %h", nm, exp, got); \
  end end
module test_mtp_pin_if;
  logic ref_clk_i, rst_i, ce_i, standard_transceiver_select_i;
  logic controller_mode_strip_i, monitor_mode_strip_i, terminal_mode_strip_i;
  logic sw_controller_enable_i, sw_monitor_enable_i, sw_terminal_enable_i;
  logic bus_a_transmitting_i, bus_b_transmitting_i, bus_a_tx_pos_i;
  logic bus_a_tx_neg_i, bus_b_tx_pos_i, bus_b_tx_neg_i;
  logic bus_a_receive_pos_i, bus_a_receive_neg_i, bus_a_mid_sync_i;
  logic bus_a_word_done_i, bus_b_word_done_i, bus_a_command_sync_i;
  logic bus_a_word_error_i, bus_b_word_error_i, bus_b_command_sync_i;
  logic [15:0] bus_a_word_i, bus_b_word_i, attack_command_o;
  logic [15:0] attack_time_stamp_o;
  logic [1:0] hub_topology_select_i;
  logic hub_transmitting_i, hub_tx_data_i, terminal_address_parity_pin_i;
  logic [4:0] hub_target_terminal_i, hub_link_select_i, hub_reply_link_i;
  logic [4:0] terminal_address_pins_i, hub_common_address_o;
  logic [30:0] hub_link_rx_i, hub_link_tx_o, line_driver_enables_o, exp;
  logic controller_mode_en_o, monitor_mode_en_o, terminal_mode_en_o;
  logic bus_a_tx_gate_o, bus_b_tx_gate_o, bus_a_std_pos_o, bus_a_std_neg_o;
  logic bus_b_std_pos_o, bus_b_std_neg_o, bus_a_disc_pos_o, bus_a_disc_neg_o;
  logic bus_b_disc_pos_o, bus_b_disc_neg_o, hub_rx_o, hub_common_address_ok_o;
  logic time_tag_top_bit_probe_o, half_megahertz_probe_o, rx_strobe_probe_o;
  logic decode_good_probe_o, bus_a_sync_type_probe_o, bus_a_activity_probe_o;
  logic attack_report_strobe_o, attack_bus_a_o, k;
  int fails = 0;
  int n_compared = 0;
  int cnt;

  mtp_pin_if dut (.*);
  mtp_xcvr_model far (.select_i(standard_transceiver_select_i),
    .tx_gate_i(bus_a_tx_gate_o), .std_pos_i(bus_a_std_pos_o),
    .std_neg_i(bus_a_std_neg_o), .disc_pos_i(bus_a_disc_pos_o),
    .disc_neg_i(bus_a_disc_neg_o), .hub_tx_i(hub_link_tx_o),
    .hub_en_i(line_driver_enables_o), .rx_pos_o(bus_a_receive_pos_i),
    .rx_neg_o(bus_a_receive_neg_i), .hub_rx_o(hub_link_rx_i));

  initial begin
    ref_clk_i = 1'h0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : step

  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    fails++;
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {controller_mode_strip_i, monitor_mode_strip_i, terminal_mode_strip_i,
      sw_controller_enable_i, sw_monitor_enable_i, sw_terminal_enable_i,
      bus_a_transmitting_i, bus_b_transmitting_i, bus_a_tx_pos_i,
      bus_a_tx_neg_i, bus_b_tx_pos_i, bus_b_tx_neg_i, bus_a_mid_sync_i,
      bus_a_word_done_i, bus_b_word_done_i, bus_a_word_error_i,
      bus_b_word_error_i, bus_a_command_sync_i, bus_b_command_sync_i,
      bus_a_word_i, bus_b_word_i, hub_topology_select_i, hub_transmitting_i,
      hub_tx_data_i, hub_target_terminal_i, hub_link_select_i,
      hub_reply_link_i, terminal_address_pins_i,
      terminal_address_parity_pin_i} = '0;
    rst_i = 1'h1;
    ce_i = 1'h1;
    standard_transceiver_select_i = 1'h1;
    step(4);
    rst_i = 1'h0;
    step(1);
    `CHK("gate", 1'h1, bus_a_tx_gate_o)
    `CHK("gate_b", 1'h1, bus_b_tx_gate_o)
    `CHK("good", 1'h1, decode_good_probe_o)
    `CHK("cmd", 16'h0000, attack_command_o)
    {bus_b_word_done_i, bus_b_command_sync_i, bus_b_word_i} = {2'h3, 16'h0801};
    step(1);
    bus_b_word_done_i = 1'h0;
    `CHK("stb", 1'h1, attack_report_strobe_o)
    `CHK("cmd", 16'h0801, attack_command_o)
    `CHK("bus", 1'h0, attack_bus_a_o)
    `CHK("stamp", 16'h0000, attack_time_stamp_o)
    {bus_b_word_done_i, bus_b_word_i} = {1'h1, 16'hf800};
    step(1);
    bus_b_word_done_i = 1'h0;
    `CHK("stb", 1'h0, attack_report_strobe_o)
    `CHK("cmd", 16'h0801, attack_command_o)
    {bus_a_word_done_i, bus_a_command_sync_i, bus_a_word_i} = {2'h3, 16'h07ff};
    {bus_b_word_done_i, bus_b_word_i} = {1'h1, 16'h0801};
    step(1);
    {bus_a_word_done_i, bus_b_word_done_i} = 2'h0;
    {bus_a_command_sync_i, bus_b_command_sync_i} = 2'h0;
    `CHK("cmd", 16'h07ff, attack_command_o)
    `CHK("bus", 1'h1, attack_bus_a_o)
    for (int i = 0; i < 4; i++) begin
      {controller_mode_strip_i, sw_controller_enable_i} = i[1:0];
      {monitor_mode_strip_i, sw_monitor_enable_i} = i[1:0];
      {terminal_mode_strip_i, sw_terminal_enable_i} = i[1:0];
      step(1);
      `CHK("ctl", i == 1, controller_mode_en_o)
      `CHK("mon", i == 1, monitor_mode_en_o)
      `CHK("term", i == 1, terminal_mode_en_o)
    end
    ce_i = 1'h0;
    controller_mode_strip_i = 1'h0;
    step(2);
    `CHK("ctl", 1'h0, controller_mode_en_o)
    ce_i = 1'h1;
    step(1);
    `CHK("ctl", 1'h1, controller_mode_en_o)
    bus_a_tx_pos_i = 1'h1;
    for (int i = 0; i < 4; i++) begin
      {standard_transceiver_select_i, bus_a_transmitting_i} = i[1:0];
      step(2);
      `CHK("gate", i[1] ^ i[0], bus_a_tx_gate_o)
      `CHK("std", i[1] & i[0], bus_a_std_pos_o)
      `CHK("disc", ~i[1] & i[0], bus_a_disc_pos_o)
      `CHK("act", i[0], bus_a_activity_probe_o)
    end
    bus_a_transmitting_i = 1'h0;
    {bus_b_word_done_i, bus_b_word_error_i} = 2'h3;
    step(1);
    {bus_b_word_done_i, bus_b_word_error_i} = 2'h0;
    `CHK("rxstb", 1'h1, rx_strobe_probe_o)
    `CHK("good", 1'h0, decode_good_probe_o)
    bus_a_word_done_i = 1'h1;
    step(1);
    bus_a_word_done_i = 1'h0;
    `CHK("good", 1'h1, decode_good_probe_o)
    {bus_a_mid_sync_i, bus_a_command_sync_i} = 2'h3;
    step(1);
    `CHK("sync", 1'h1, bus_a_sync_type_probe_o)
    bus_a_command_sync_i = 1'h0;
    step(1);
    bus_a_mid_sync_i = 1'h0;
    `CHK("sync", 1'h0, bus_a_sync_type_probe_o)
    {hub_transmitting_i, hub_tx_data_i, terminal_address_parity_pin_i} = 3'h7;
    {hub_target_terminal_i, hub_link_select_i} = {5'h03, 5'h07};
    terminal_address_pins_i = 5'h05;
    for (int i = 0; i < 4; i++) begin
      hub_topology_select_i = i[1:0];
      step(1);
      exp = (i < 2) ? '1 : (i == 2) ? 31'h8 : 31'h80;
      `CHK("de", exp, line_driver_enables_o)
      `CHK("htx", exp, hub_link_tx_o)
    end
    hub_tx_data_i = 1'h0;
    step(2);
    `CHK("hrx", 1'h0, hub_rx_o)
    `CHK("addr", 5'h05, hub_common_address_o)
    `CHK("addr_ok", 1'h1, hub_common_address_ok_o)
    hub_transmitting_i = 1'h0;
    step(1);
    `CHK("de", 31'h0, line_driver_enables_o)
    for (int j = 0; j < 2; j++) begin
      k = half_megahertz_probe_o;
      cnt = 0;
      while (half_megahertz_probe_o === k && cnt < 30) begin
        step(1);
        cnt++;
      end
    end
    `CHK("half", 10, cnt)
    step(700);
    {bus_a_word_done_i, bus_a_command_sync_i, bus_a_word_i} = {2'h3, 16'h0001};
    step(1);
    {bus_a_word_done_i, bus_a_command_sync_i} = 2'h0;
    `CHK("stamp", 16'h0001, attack_time_stamp_o)
    rst_i = 1'h1;
    step(2);
    `CHK("tt", 1'h0, time_tag_top_bit_probe_o)
    `CHK("stamp", 16'h0000, attack_time_stamp_o)
    rst_i = 1'h0;
    step(1);
    report_and_stop();
  end
endmodule : test_mtp_pin_if
